// [asc_pkg.sv]
/*
  asc_pkg: constants shared by the serial converter frame controller.
  Assumes a single ref_clk domain; serial clock and frame select are sampled pins.
*/
package asc_pkg;
  localparam int unsigned REF_CLK_HZ       = 20_000_000;
  localparam int unsigned DATA_BITS        = 12;
  localparam int unsigned LEAD_ZEROS       = 3;
  localparam int unsigned FIFO_DEPTH       = 8;
  localparam logic [4:0]  NOISE_EDGES      = 5'h02;
  localparam logic [4:0]  SHUTDOWN_EDGES   = 5'h0A;
  localparam logic [4:0]  FRAME_EDGES      = 5'h10;
  localparam logic [4:0]  TRACK_RISE_EDGE  = 5'h0D;
  localparam logic [4:0]  POWERUP_EDGES    = 5'h10;
  localparam logic [4:0]  LEAD_END_EDGE    = 5'h03;
  localparam logic        RST_SHUTDOWN     = 1'b0;
  localparam logic        RST_WARM         = 1'b0;

  typedef enum logic [1:0] {
    ASC_IDLE  = 2'b00,
    ASC_FRAME = 2'b01,
    ASC_DONE  = 2'b11
  } asc_state_t;
endpackage

// [asc_sync.sv]
/*
  asc_sync: two-flop synchroniser for one pin input.
  Assumes the input is asynchronous to clk; output is the second flop only.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  input  wire logic din,
  output var  logic dout
);
  logic meta_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      meta_r <= INIT;
      dout   <= INIT;
    end else if (ce) begin
      meta_r <= din;
      dout   <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [asc_fifo.sv]
/*
  asc_fifo: small synchronous FIFO with valid/ready on both sides.
  Assumes one clock; ce freezes all state.
*/
`timescale 1ns/1ps
`default_nettype none
module asc_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  output var  logic [WIDTH-1:0] out_data,
  output var  logic             out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // full compare at AW+1 bits; an AW-bit depth would wrap to zero
  assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (ce) begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// [asc_frame_ctrl.sv]
/*
  asc_frame_ctrl: frame, shift-out and power-mode control of a 12-bit serial converter.
  Assumes ref_clk is much faster than the serial clock; pins are sampled here.
  Conversion results arrive from the converter core through an internal FIFO.
*/
// Behaviour
// - select falling starts conversion, normal mode
// - rise between edges 2 and 10: shutdown
// - rise before edge 2 keeps mode
// - shutdown holds until select falls again; code keeps shutdown_mode until the tenth falling edge
// - rise between edges 10 and 16 truncates
// - output released after sixteenth clock
// - leaving shutdown: first result unusable
// - second conversion after power-up valid
// - fully powered after 16 clocks
// - power-on mode either; dummy conversion advised
// - shutdown turns all analog circuitry off
// - three zeros then twelve bits, MSB first
// - select falling: output driven, input held
// - track resumes on 13th rising edge
// - host captures on following falling edge
`timescale 1ns/1ps
`default_nettype none
module asc_frame_ctrl
  import asc_pkg::*;
#(
  parameter int unsigned WIDTH = asc_pkg::DATA_BITS,
  parameter int unsigned DEPTH = asc_pkg::FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic             frame_sel_n,
  input  wire logic             serial_clk,
  output logic                  serial_result_out,
  output logic                  serial_result_oe,
  input  wire logic [WIDTH-1:0] sample_data,
  input  wire logic             sample_valid,
  output logic                  sample_ready,
  output logic                  hold_mode,
  output logic                  analog_on,
  output logic                  result_usable,
  output logic                  shutdown_mode
);
  import asc_pkg::*;

  logic             sel_s;
  logic             sclk_s;
  logic             sel_d_r;
  logic             sclk_d_r;
  logic             sel_fall;
  logic             sel_rise;
  logic             sclk_fall;
  logic             sclk_rise;
  asc_state_t       state_r;
  logic [4:0]       fall_cnt_r;
  logic [4:0]       rise_cnt_r;
  logic [WIDTH-1:0] shift_r;
  logic [WIDTH-1:0] fifo_data;
  logic             fifo_valid;
  logic             fifo_take;
  logic             dummy_r;
  logic             pwr_cnt_done_r;

  asc_sync #(.INIT(1'b1)) u_sync_sel (
    .clk   (ref_clk),
    .reset (reset),
    .ce    (clk_en),
    .din   (frame_sel_n),
    .dout  (sel_s)
  );

  asc_sync #(.INIT(1'b0)) u_sync_sclk (
    .clk   (ref_clk),
    .reset (reset),
    .ce    (clk_en),
    .din   (serial_clk),
    .dout  (sclk_s)
  );

  // core results queue here; back-pressure stalls the core when no frame drains it
  asc_fifo #(.WIDTH(WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk       (ref_clk),
    .reset     (reset),
    .ce        (clk_en),
    .in_data   (sample_data),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_take)
  );

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      sel_d_r  <= 1'b1;
      sclk_d_r <= 1'b0;
    end else if (clk_en) begin
      sel_d_r  <= sel_s;
      sclk_d_r <= sclk_s;
    end
  end

  assign sel_fall  = sel_d_r && !sel_s;
  assign sel_rise  = !sel_d_r && sel_s;
  assign sclk_fall = sclk_d_r && !sclk_s && !sel_s;
  assign sclk_rise = !sclk_d_r && sclk_s && !sel_s;
  // sample taken at the instant of select falling; an empty queue gives zeros
  assign fifo_take = sel_fall;

  // frame sequencing
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ASC_IDLE;
    end else if (clk_en) begin
      case (state_r)
        ASC_IDLE: begin
          if (sel_fall) begin
            state_r <= ASC_FRAME;
          end
        end
        ASC_FRAME: begin
          if (sel_rise) begin
            state_r <= ASC_IDLE;
          end else if (sclk_fall && fall_cnt_r == FRAME_EDGES - 5'h01) begin
            state_r <= ASC_DONE;
          end
        end
        ASC_DONE: begin
          // select held low after a full word needs a rise first
          if (sel_rise) begin
            state_r <= ASC_IDLE;
          end
        end
        default: state_r <= ASC_IDLE;
      endcase
    end
  end

  // falling and rising edge counts within the frame
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      fall_cnt_r <= '0;
      rise_cnt_r <= '0;
    end else if (clk_en) begin
      if (sel_rise || sel_fall) begin
        fall_cnt_r <= '0;
        rise_cnt_r <= '0;
      end else if (state_r != ASC_IDLE) begin
        if (sclk_fall && fall_cnt_r != 5'h1F) begin
          fall_cnt_r <= fall_cnt_r + 5'h01;
        end
        if (sclk_rise && rise_cnt_r != 5'h1F) begin
          rise_cnt_r <= rise_cnt_r + 5'h01;
        end
      end
    end
  end

  // power mode on select rise
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shutdown_mode <= RST_SHUTDOWN;
    end else if (clk_en) begin
      if (sel_rise && state_r == ASC_FRAME) begin
        if (fall_cnt_r < NOISE_EDGES) begin
          shutdown_mode <= shutdown_mode;
        end else if (fall_cnt_r < SHUTDOWN_EDGES) begin
          shutdown_mode <= 1'b1;
        end else begin
          shutdown_mode <= 1'b0;
        end
      end else if (state_r == ASC_FRAME && fall_cnt_r >= SHUTDOWN_EDGES) begin
        shutdown_mode <= 1'b0;
      end
      // otherwise shutdown persists until the tenth falling edge of a frame
    end
  end

  // analog power: off in shutdown except while a frame is powering up
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      analog_on <= 1'b0;
    end else if (clk_en) begin
      analog_on <= !shutdown_mode || (state_r == ASC_FRAME) || sel_fall;
    end
  end

  // dummy conversion after leaving shutdown; power-up done after 16 clocks
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      dummy_r        <= 1'b1;
      pwr_cnt_done_r <= RST_WARM;
    end else if (clk_en) begin
      if (sel_fall) begin
        dummy_r <= shutdown_mode || !pwr_cnt_done_r;
        if (shutdown_mode) begin
          pwr_cnt_done_r <= 1'b0;
        end
      end else if (state_r != ASC_IDLE && sclk_fall && fall_cnt_r == POWERUP_EDGES - 5'h01) begin
        pwr_cnt_done_r <= 1'b1;
      end
    end
  end

  // qualifies the result of the current frame; next frame after power-up is valid
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      result_usable <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall) begin
        result_usable <= !(shutdown_mode || !pwr_cnt_done_r);
      end
    end
  end

  // track/hold: hold from select fall until 13th rising edge
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      hold_mode <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall) begin
        hold_mode <= 1'b1;
      end else if (sel_rise) begin
        hold_mode <= 1'b0;
      end else if (sclk_rise && rise_cnt_r == TRACK_RISE_EDGE - 5'h01) begin
        hold_mode <= 1'b0;
      end
    end
  end

  // output shifter: zeros during lead-in, then MSB first on falling edges
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      shift_r           <= '0;
      serial_result_out <= 1'b0;
      serial_result_oe  <= 1'b0;
    end else if (clk_en) begin
      if (sel_fall) begin
        shift_r           <= fifo_valid ? fifo_data : '0;
        serial_result_out <= 1'b0;
        serial_result_oe  <= 1'b1;
      end else if (sel_rise) begin
        serial_result_oe  <= 1'b0;
      end else if (state_r == ASC_FRAME && sclk_fall) begin
        if (fall_cnt_r == FRAME_EDGES - 5'h01) begin
          serial_result_oe <= 1'b0;
        end else if (fall_cnt_r >= LEAD_END_EDGE - 5'h01) begin
          // bit changes on a falling edge, host samples on the next
          serial_result_out <= shift_r[WIDTH-1];
          shift_r           <= {shift_r[WIDTH-2:0], 1'b0};
        end else begin
          serial_result_out <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [asc_frame_ctrl_monitor.sv]
/* asc_frame_ctrl_monitor: pin-level checks of the frame controller.
   Assumes raw pins lead the design by its 3-4 cycle sync path. */
`timescale 1ns/1ps
`default_nettype none
module asc_frame_ctrl_monitor #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic frame_sel_n,
  input wire logic serial_clk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe,
  input wire logic analog_on,
  input wire logic result_usable,
  input wire logic shutdown_mode
);
  logic       sclk_r;
  logic [4:0] falls_r;
  // raw fall count, so it runs ahead of the design's own count
  always_ff @(posedge ref_clk) begin
    sclk_r <= serial_clk;
    if (reset || frame_sel_n) begin
      falls_r <= 5'h00;
    end else if (sclk_r && !serial_clk) begin
      falls_r <= falls_r + 5'h01;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  chk_lead_zero: assert property ($fell(frame_sel_n) |-> ##[3:6]
    serial_result_oe && !serial_result_out) else $error("no lead zero");
  chk_release_last: assert property ($rose(falls_r == 5'h10) |-> ##[2:7]
    !serial_result_oe) else $error("output kept after last fall");
  chk_release_rise: assert property ($rose(frame_sel_n) |-> ##[1:7]
    !serial_result_oe) else $error("output kept after select rise");
  chk_sleep_entry: assert property ($rose(frame_sel_n) && falls_r inside {[2:9]}
    |-> ##[2:8] shutdown_mode) else $error("no shutdown");
  chk_noise_keep: assert property ($rose(frame_sel_n) && falls_r < 5'h02
    |=> $stable(shutdown_mode) [*8]) else $error("mode changed by short frame");
  chk_trunc_normal: assert property ($rose(frame_sel_n) && falls_r inside {[10:15]}
    |-> ##6 !shutdown_mode) else $error("truncated frame left normal mode");
  chk_sleep_holds: assert property (shutdown_mode && frame_sel_n |=>
    shutdown_mode) else $error("left shutdown with select high");
  chk_analog_off: assert property ((shutdown_mode && frame_sel_n) [*8] |-> !analog_on)
    else $error("analog on in shutdown");
  chk_usable_fall: assert property ($changed(result_usable) |-> !frame_sel_n)
    else $error("usable flag moved outside a frame");
  cover property ($rose(shutdown_mode));
  cover property ($rose(falls_r == 5'h10));
  cover property ($rose(result_usable));
endmodule
bind asc_frame_ctrl asc_frame_ctrl_monitor #(.WIDTH(WIDTH), .DEPTH(DEPTH)) mon_u (
  .ref_clk(ref_clk), .reset(reset), .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
  .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
  .analog_on(analog_on), .result_usable(result_usable), .shutdown_mode(shutdown_mode));
`default_nettype wire

// [asc_host_model.sv]
/* asc_host_model: host serial controller driving select and serial clock.
   Assumes ref_clk from the bench; pins change on its falling edge. */
`timescale 1ns/1ps
`default_nettype none
module asc_host_model (
  input  wire logic        ref_clk,
  input  wire logic        serial_result_out,
  input  wire logic        serial_result_oe,
  output var  logic        frame_sel_n,
  output var  logic        serial_clk,
  output var  logic [15:0] word,
  output var  logic        oe_at_end
);
  // no pull on the line: released it shows the inverse
  wire line = serial_result_oe ? serial_result_out : ~serial_result_out;
  initial begin
    frame_sel_n = 1'b1;
    serial_clk  = 1'b1;
    word        = 16'h0000;
    oe_at_end   = 1'b0;
  end
  // clock stands high outside frames; half sets the pace
  task automatic frame(input int falls, input int half);
    word = 16'h0000;
    @(negedge ref_clk) frame_sel_n = 1'b0;
    repeat (2 * half) @(negedge ref_clk);
    for (int i = 0; i < falls; i++) begin
      word = {word[14:0], line};
      serial_clk = 1'b0;
      repeat (half) @(negedge ref_clk);
      serial_clk = 1'b1;
      repeat (half) @(negedge ref_clk);
    end
    oe_at_end = serial_result_oe;
    frame_sel_n = 1'b1;
    repeat (4 * half) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

// [testbench.sv]
/* testbench: frame, shutdown and wake-up scenarios for asc_frame_ctrl.
   Assumes asc_host_model drives the pins; the bench feeds the sample FIFO. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import asc_pkg::*;
  logic        ref_clk      = 1'b0;
  logic        reset        = 1'b1;
  logic [11:0] sample_data  = 12'h000;
  logic        sample_valid = 1'b0;
  wire         frame_sel_n, serial_clk, serial_result_out, serial_result_oe;
  wire         sample_ready, hold_mode, analog_on, result_usable, shutdown_mode;
  wire  [15:0] word;
  wire         oe_at_end;
  int          mismatches   = 0;
  int          checks       = 0;
  always #25 ref_clk = ~ref_clk;
  asc_frame_ctrl dut_u (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1),
    .frame_sel_n(frame_sel_n), .serial_clk(serial_clk),
    .serial_result_out(serial_result_out), .serial_result_oe(serial_result_oe),
    .sample_data(sample_data), .sample_valid(sample_valid), .sample_ready(sample_ready),
    .hold_mode(hold_mode), .analog_on(analog_on), .result_usable(result_usable),
    .shutdown_mode(shutdown_mode));
  asc_host_model host_u (.ref_clk(ref_clk), .serial_result_out(serial_result_out),
    .serial_result_oe(serial_result_oe), .frame_sel_n(frame_sel_n),
    .serial_clk(serial_clk), .word(word), .oe_at_end(oe_at_end));
  function automatic logic [11:0] dat(input int i);
    return 12'h9A5 + 12'(i * 291);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask
  task automatic t_reset();
    check(16'({serial_result_oe, shutdown_mode, result_usable}), 16'h0000, "rst");
    $display("test reset done");
  endtask
  task automatic t_fill();
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk);
      check(16'(sample_ready), 16'h0001, "space");
      sample_data  = dat(i);
      sample_valid = 1'b1;
    end
    @(negedge ref_clk);
    check(16'(sample_ready), 16'h0000, "full");
    // this push must be refused, so the ninth frame shifts zeros
    sample_data = 12'hFFF;
    @(negedge ref_clk);
    sample_valid = 1'b0;
    $display("test fill done");
  endtask
  task automatic t_normal();
    host_u.frame(16, 4);
    check(16'(result_usable), 16'h0000, "dummy");
    check(16'(word[15:1]), 16'(dat(0)), "word0");
    check(16'(oe_at_end), 16'h0000, "oe end");
    check(16'(hold_mode), 16'h0000, "track");
    host_u.frame(16, 8);
    check(16'({result_usable, analog_on}), 16'h0003, "valid");
    check(16'(word[15:1]), 16'(dat(1)), "word1");
    $display("test normal done");
  endtask
  task automatic t_sleep();
    host_u.frame(1, 4);
    check(16'(shutdown_mode), 16'h0000, "noise");
    host_u.frame(5, 4);
    check(16'({shutdown_mode, analog_on}), 16'h0002, "sleep");
    host_u.frame(1, 4);
    check(16'(shutdown_mode), 16'h0001, "stay");
    $display("test sleep done");
  endtask
  task automatic t_wake();
    host_u.frame(12, 4);
    check(16'({shutdown_mode, result_usable}), 16'h0000, "wake");
    host_u.frame(16, 4);
    check(16'(result_usable), 16'h0000, "powering");
    host_u.frame(12, 4);
    check(16'({shutdown_mode, result_usable}), 16'h0001, "trunc");
    // 20-clock frame: last four captures see the released line
    host_u.frame(20, 4);
    check(word, 16'h000F, "empty");
    check(16'(sample_ready), 16'h0001, "drained");
    $display("test wake done");
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge ref_clk);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    t_reset();
    t_fill();
    t_normal();
    t_sleep();
    t_wake();
    end_sim();
  end
endmodule
`default_nettype wire
